// *** ufsp_top.sv ***
// Four-mode serial port: control and data registers, shifters, framing.
//
// What this block does
// - Four modes: sync 8-bit, async 8 or 9.
// - Mode 0: data on receive pin, clock out.
// - Mode 0 write shifts eight bits, flag after.
// - Mode 0 receive when enabled and flag clear.
// - Mode 0 shift clock is core clock/12.
// - Mode 0 receive pin only pulled low.
// - Mode 1 frame: start, eight data, stop.
// - Async write starts; flag at stop start.
// - Async receive only when enable bit set.
// - Mode 1 load gated by flag, stop bit.
// - Timer overflow clocks baud, divided by sixteen.
// - Timer 1 rate halved unless doubler set.
// - Timer 2 selects take its overflow instead.
// - Modes 2, 3: ninth bit from control field.
// - Modes 2, 3 load gated by flag, ninth.
// - Mode 2 rate core/64, core/32 doubled.
// - Mode 3 is mode 2 framing, timer rate.
// - Interrupt when enabled and either flag set.
// - Data address: write transmits, read receives.
// - Two mode bits choose the mode.
// - Flags cleared only by software writes.
`timescale 1ns/100ps
module ufsp_top import ufsp_pkg::*; (
    // Clock, reset and clock enable.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Special function register port.
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    // Baud configuration and timer overflow pulses.
    input wire logic baud_doubler_i,
    input wire logic tx_timer2_baud_select_i,
    input wire logic rx_timer2_baud_select_i,
    input wire logic timer1_ovf_i,
    input wire logic timer2_ovf_i,
    output logic timer2_irq_block_o,
    // Interrupt.
    input wire logic irq_enable_i,
    output logic irq_o,
    // Serial pins; the receive pin is two-way.
    input wire logic rxd_i,
    output logic rxd_o,
    output logic rxd_oe_o,
    output logic txd_o
);
    typedef struct packed {
        ufsp_mode_type mode;
        logic mpe;
        logic ren;
        logic tb8;
        logic rb8;
        logic ti;
        logic ri;
        logic [7:0] rx_buf;
        ufsp_tx_state_type tx_st;
        logic [3:0] tx_ph;
        logic [3:0] tx_cnt;
        logic [8:0] tx_sh;
        ufsp_rx_state_type rx_st;
        logic [3:0] rx_ph;
        logic [3:0] rx_cnt;
        logic [8:0] rx_sh;
        logic rx_prev;
        logic [3:0] m0_ph;
        logic txd;
        logic rxd_out;
        logic rxd_oe;
        logic irq;
        logic t2_block;
        logic [7:0] rdata;
    } ufsp_state_type;

    ufsp_state_type q;
    ufsp_state_type d;
    logic rxf;
    logic tx16;
    logic rx16;
    logic wr_ctrl;
    logic wr_data;
    logic rx_fin;

    ufsp_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .pin_i(rxd_i),
        .level_o(rxf)
    );

    ufsp_baud u_baud (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .mode_i(q.mode),
        .baud_doubler_i(baud_doubler_i),
        .tx_t2_sel_i(tx_timer2_baud_select_i),
        .rx_t2_sel_i(rx_timer2_baud_select_i),
        .t1_ovf_i(timer1_ovf_i),
        .t2_ovf_i(timer2_ovf_i),
        .tx16_o(tx16),
        .rx16_o(rx16)
    );

    assign wr_ctrl = sfr_wr_i && (sfr_addr_i == UFSP_CTRL_ADDR);
    assign wr_data = sfr_wr_i && (sfr_addr_i == UFSP_DATA_ADDR);

    always_comb begin
        d = q;
        rx_fin = 1'b0;
        // Software writes first, so a hardware set below wins.
        if (wr_ctrl) begin
            d.mode = ufsp_mode_type'(
                sfr_wdata_i[UFSP_MSEL_HI_POS:UFSP_MSEL_LO_POS]);
            d.mpe = sfr_wdata_i[UFSP_MPE_POS];
            d.ren = sfr_wdata_i[UFSP_REN_POS];
            d.tb8 = sfr_wdata_i[UFSP_TB8_POS];
            d.rb8 = sfr_wdata_i[UFSP_RB8_POS];
            d.ti = sfr_wdata_i[UFSP_TI_POS];
            d.ri = sfr_wdata_i[UFSP_RI_POS];
        end

        // Transmitter. A write while busy is dropped to keep frames whole.
        case (q.tx_st)
            TX_IDLE: begin
                if (wr_data && q.rx_st != RX_SYNC
                        && q.rx_st != RX_SYNC_END) begin
                    d.tx_sh = {q.tb8, sfr_wdata_i};
                    d.tx_ph = 4'h0;
                    d.tx_cnt = 4'h0;
                    d.m0_ph = 4'h0;
                    if (q.mode == MODE_SYNC) begin
                        d.tx_st = TX_SYNC;
                    end else begin
                        d.tx_st = TX_START;
                    end
                end
            end
            TX_SYNC: begin
                if (q.m0_ph == UFSP_M0_LAST) begin
                    d.tx_sh = q.tx_sh >> 1;
                    d.tx_cnt = q.tx_cnt + 4'h1;
                    if (q.tx_cnt == UFSP_DATA_BITS - 4'h1) begin
                        d.ti = 1'b1;
                        d.tx_st = TX_IDLE;
                    end
                end
            end
            TX_START: begin
                if (tx16 && q.tx_ph == UFSP_OVS_LAST) begin
                    d.tx_st = TX_DATA;
                end
            end
            TX_DATA: begin
                if (tx16 && q.tx_ph == UFSP_OVS_LAST) begin
                    d.tx_sh = q.tx_sh >> 1;
                    d.tx_cnt = q.tx_cnt + 4'h1;
                    if (q.tx_cnt == UFSP_DATA_BITS - 4'h1) begin
                        if (ufsp_nine_bit(q.mode)) begin
                            d.tx_st = TX_NINTH;
                        end else begin
                            d.tx_st = TX_STOP;
                            d.ti = 1'b1;
                        end
                    end
                end
            end
            TX_NINTH: begin
                if (tx16 && q.tx_ph == UFSP_OVS_LAST) begin
                    d.tx_st = TX_STOP;
                    d.ti = 1'b1;
                end
            end
            TX_STOP: begin
                if (tx16 && q.tx_ph == UFSP_OVS_LAST) begin
                    d.tx_st = TX_IDLE;
                end
            end
            default: d.tx_st = TX_IDLE;
        endcase
        if (tx16 && q.tx_st != TX_IDLE && q.tx_st != TX_SYNC) begin
            d.tx_ph = q.tx_ph + 4'h1;
        end

        // Receiver.
        case (q.rx_st)
            RX_IDLE: begin
                if (q.ren && q.mode == MODE_SYNC) begin
                    if (!q.ri && q.tx_st == TX_IDLE && !wr_data) begin
                        d.rx_st = RX_SYNC;
                        d.rx_cnt = 4'h0;
                        d.m0_ph = 4'h0;
                    end
                end else if (q.ren && q.rx_prev && !rxf) begin
                    d.rx_st = RX_START;
                    d.rx_ph = 4'h0;
                    d.rx_cnt = 4'h0;
                end
            end
            RX_SYNC: begin
                // Sample on the rising edge of the shift clock.
                if (q.m0_ph == UFSP_M0_HALF) begin
                    d.rx_sh = {rxf, q.rx_sh[8:1]};
                end
                if (q.m0_ph == UFSP_M0_LAST) begin
                    d.rx_cnt = q.rx_cnt + 4'h1;
                    if (q.rx_cnt == UFSP_DATA_BITS - 4'h1) begin
                        d.rx_st = RX_SYNC_END;
                    end
                end
            end
            RX_SYNC_END: begin
                d.rx_buf = q.rx_sh[8:1];
                d.ri = 1'b1;
                d.rx_st = RX_IDLE;
            end
            RX_START: begin
                if (rx16 && q.rx_ph == UFSP_OVS_MID && rxf) begin
                    d.rx_st = RX_IDLE;
                end else if (rx16 && q.rx_ph == UFSP_OVS_LAST) begin
                    d.rx_st = RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx16 && q.rx_ph == UFSP_OVS_MID) begin
                    d.rx_sh = {rxf, q.rx_sh[8:1]};
                    d.rx_cnt = q.rx_cnt + 4'h1;
                    if (q.rx_cnt == UFSP_DATA_BITS) begin
                        if (ufsp_nine_bit(q.mode)) begin
                            d.rx_st = RX_STOP;
                        end else begin
                            rx_fin = 1'b1;
                            d.rx_st = RX_IDLE;
                        end
                    end
                end
            end
            RX_STOP: begin
                // The stop bit level is not checked in 9-bit modes.
                if (rx16 && q.rx_ph == UFSP_OVS_MID) begin
                    rx_fin = 1'b1;
                    d.rx_st = RX_IDLE;
                end
            end
            default: d.rx_st = RX_IDLE;
        endcase
        if (rx16 && q.rx_st != RX_IDLE && q.rx_st != RX_SYNC
                && q.rx_st != RX_SYNC_END) begin
            d.rx_ph = q.rx_ph + 4'h1;
        end
        d.rx_prev = rxf;

        // The ninth received bit is the stop bit in mode 1.
        if (rx_fin && !q.ri && (!q.mpe || d.rx_sh[8])) begin
            d.rx_buf = d.rx_sh[7:0];
            d.rb8 = d.rx_sh[8];
            d.ri = 1'b1;
        end

        // Shared mode 0 bit timer.
        if (q.tx_st == TX_SYNC || q.rx_st == RX_SYNC) begin
            d.m0_ph = (q.m0_ph == UFSP_M0_LAST) ? 4'h0
                : q.m0_ph + 4'h1;
        end

        // Pins, from the next state so they line up with it.
        d.rxd_out = 1'b0;
        d.rxd_oe = 1'b0;
        if (d.tx_st == TX_SYNC || d.rx_st == RX_SYNC) begin
            d.txd = (d.m0_ph >= UFSP_M0_HALF);
            if (d.tx_st == TX_SYNC) begin
                d.rxd_oe = ~d.tx_sh[0];
            end
        end else begin
            case (d.tx_st)
                TX_START: d.txd = 1'b0;
                TX_DATA: d.txd = d.tx_sh[0];
                TX_NINTH: d.txd = d.tx_sh[0];
                default: d.txd = UFSP_LINE_IDLE;
            endcase
        end

        d.irq = irq_enable_i && (q.ti || q.ri);
        d.t2_block = tx_timer2_baud_select_i
            || rx_timer2_baud_select_i;

        if (sfr_rd_i) begin
            if (sfr_addr_i == UFSP_CTRL_ADDR) begin
                d.rdata = {q.mode, q.mpe, q.ren, q.tb8, q.rb8, q.ti, q.ri};
            end else if (sfr_addr_i == UFSP_DATA_ADDR) begin
                d.rdata = q.rx_buf;
            end else begin
                d.rdata = UFSP_REG_RESET;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.txd <= UFSP_LINE_IDLE;
            q.rx_prev <= UFSP_LINE_IDLE;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign sfr_rdata_o = q.rdata;
    assign timer2_irq_block_o = q.t2_block;
    assign irq_o = q.irq;
    assign rxd_o = q.rxd_out;
    assign rxd_oe_o = q.rxd_oe;
    assign txd_o = q.txd;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || !ce_i);

    sequence m0_clk_cycle;
        !q.txd [*6] ##1 q.txd [*6];
    endsequence

    a_m0_clock_div: assert property (
        ($fell(q.txd) && q.tx_st == TX_SYNC && q.tx_cnt == 4'h0)
            |-> m0_clk_cycle)
        else $error("Mode 0 shift clock is not twelve clocks.");
    a_ti_at_stop: assert property (
        $rose(q.tx_st == TX_STOP) |-> q.ti && q.txd)
        else $error("Transmit flag not set at stop bit.");
    a_start_bit_low: assert property (
        q.tx_st == TX_START |-> !q.txd)
        else $error("Start bit not low.");
    a_ren_gates_rx: assert property (
        (q.rx_st == RX_IDLE && !q.ren) |=> q.rx_st == RX_IDLE)
        else $error("Reception started while disabled.");
    a_flag_sticky: assert property (
        (q.ri && !wr_ctrl) |=> q.ri)
        else $error("Receive flag cleared without a write.");
    a_rxbuf_held: assert property (
        (q.ri && !wr_ctrl) |=> $stable(q.rx_buf))
        else $error("Receive buffer changed while flag set.");
    a_oe_mode0_only: assert property (
        q.rxd_oe |-> q.mode == MODE_SYNC && !q.rxd_out)
        else $error("Receive pin driven outside mode 0.");
    a_irq_follows: assert property (
        (irq_enable_i && (q.ti || q.ri)) |=> irq_o)
        else $error("Interrupt not raised for a set flag.");
endmodule

// *** ufsp_pkg.sv ***
// Shared constants and types of the four-mode serial port.
package ufsp_pkg;
    // Register addresses and reset value.
    localparam logic [7:0] UFSP_CTRL_ADDR = 8'h98;
    localparam logic [7:0] UFSP_DATA_ADDR = 8'h99;
    localparam logic [7:0] UFSP_REG_RESET = 8'h00;
    // Field positions in serial_control_reg.
    localparam int UFSP_MSEL_HI_POS = 7;
    localparam int UFSP_MSEL_LO_POS = 6;
    localparam int UFSP_MPE_POS = 5;
    localparam int UFSP_REN_POS = 4;
    localparam int UFSP_TB8_POS = 3;
    localparam int UFSP_RB8_POS = 2;
    localparam int UFSP_TI_POS = 1;
    localparam int UFSP_RI_POS = 0;
    // Mode 0 bit time is twelve core clocks, clock low for the first half.
    localparam logic [3:0] UFSP_M0_LAST = 4'hb;
    localparam logic [3:0] UFSP_M0_HALF = 4'h6;
    // Asynchronous bits span sixteen baud ticks, sampled at the middle.
    localparam logic [3:0] UFSP_OVS_LAST = 4'hf;
    localparam logic [3:0] UFSP_OVS_MID = 4'h7;
    localparam logic [3:0] UFSP_DATA_BITS = 4'h8;
    // Mode 2 tick prescale: core/4 or core/2 gives core/64 or core/32 a bit.
    localparam logic [1:0] UFSP_M2_PRE_SLOW = 2'h3;
    localparam logic [1:0] UFSP_M2_PRE_FAST = 2'h1;
    localparam logic UFSP_LINE_IDLE = 1'b1;

    typedef enum logic [1:0] {
        MODE_SYNC, MODE_8BIT, MODE_9BIT_FIXED, MODE_9BIT_VAR
    } ufsp_mode_type;
    typedef enum logic [2:0] {
        TX_IDLE, TX_SYNC, TX_START, TX_DATA, TX_NINTH, TX_STOP
    } ufsp_tx_state_type;
    typedef enum logic [2:0] {
        RX_IDLE, RX_SYNC, RX_SYNC_END, RX_START, RX_DATA, RX_STOP
    } ufsp_rx_state_type;

    function automatic logic ufsp_nine_bit(input ufsp_mode_type m);
        ufsp_nine_bit = (m == MODE_9BIT_FIXED) || (m == MODE_9BIT_VAR);
    endfunction
endpackage

// *** ufsp_sync.sv ***
// Three-stage input synchroniser with agreement filter for the receive pin.
`timescale 1ns/100ps
module ufsp_sync import ufsp_pkg::*; (
    // Clock and control.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Pin in, filtered level out.
    input wire logic pin_i,
    output logic level_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } ufsp_sync_state_type;

    ufsp_sync_state_type q;
    ufsp_sync_state_type d;

    // A change counts only once the second and third stage agree.
    always_comb begin
        d = q;
        d.s1 = pin_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.s2 == q.s3) begin
            d.lvl = q.s3;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= {4{UFSP_LINE_IDLE}};
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign level_o = q.lvl;
endmodule

// *** ufsp_baud.sv ***
// Sixteen-times baud tick generator for transmit and receive.
`timescale 1ns/100ps
module ufsp_baud import ufsp_pkg::*; (
    // Clock and control.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Configuration.
    input wire ufsp_mode_type mode_i,
    input wire logic baud_doubler_i,
    input wire logic tx_t2_sel_i,
    input wire logic rx_t2_sel_i,
    // Timer overflow pulses.
    input wire logic t1_ovf_i,
    input wire logic t2_ovf_i,
    // Tick pulses.
    output logic tx16_o,
    output logic rx16_o
);
    typedef struct packed {
        logic [1:0] pre;
        logic t1_half;
        logic tx16;
        logic rx16;
    } ufsp_baud_state_type;

    ufsp_baud_state_type q;
    ufsp_baud_state_type d;
    logic m2_tick;
    logic t1_tick;
    logic [1:0] pre_lim;

    always_comb begin
        d = q;
        pre_lim = baud_doubler_i ? UFSP_M2_PRE_FAST : UFSP_M2_PRE_SLOW;
        m2_tick = (q.pre == pre_lim);
        d.pre = m2_tick ? 2'h0 : q.pre + 2'h1;
        // Without the doubler, every second timer 1 overflow is used.
        if (t1_ovf_i) begin
            d.t1_half = ~q.t1_half;
        end
        t1_tick = t1_ovf_i && (baud_doubler_i || q.t1_half);
        // One overflow is one tick; sixteen ticks make a bit.
        if (mode_i == MODE_9BIT_FIXED) begin
            d.tx16 = m2_tick;
            d.rx16 = m2_tick;
        end else if (mode_i == MODE_SYNC) begin
            d.tx16 = 1'b0;
            d.rx16 = 1'b0;
        end else begin
            d.tx16 = tx_t2_sel_i ? t2_ovf_i : t1_tick;
            d.rx16 = rx_t2_sel_i ? t2_ovf_i : t1_tick;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign tx16_o = q.tx16;
    assign rx16_o = q.rx16;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || !ce_i);

    // A mode or doubler change mid-period legally breaks the cadence.
    a_mode2_slow_rate: assert property (
        disable iff (rst_i || !ce_i || baud_doubler_i
            || mode_i != MODE_9BIT_FIXED)
        (q.tx16 && $stable(mode_i)) |-> ##1 !q.tx16 [*3] ##1 q.tx16)
        else $error("Mode 2 tick not every fourth clock.");
endmodule

// *** ufsp_partner.sv ***
// Remote serial partner: drives the receive pin and decodes the transmit pin.
`timescale 1ns/100ps
module ufsp_partner (
    // Clock and wires.
    input wire logic clk_i,
    input wire logic txd_i,
    input wire logic rxd_i,
    // Decode control: 1 watches mode 0 shifting, 2 async frames.
    input wire logic [1:0] watch_i,
    input wire logic [7:0] per_i,
    input wire logic nine_i,
    // Released line level and decoded frames.
    output logic line_o,
    output logic got_v_o,
    output logic [15:0] got_o
);
    int cyc = 0;
    int last = 0;
    int gap;
    int n = 0;
    logic [8:0] sh;
    logic [10:0] fr;
    initial begin
        line_o = 1'b1;
        got_v_o = 1'b0;
        got_o = 16'h0;
    end
    always @(posedge clk_i) cyc++;
    // Mode 0 slave: sample the data wire on each rising shift clock.
    always @(posedge txd_i) begin
        if (watch_i == 2'd1) begin
            gap = cyc - last;
            last = cyc;
            sh = {rxd_i, sh[8:1]};
            n = n + 1;
            if (n == 8) begin
                n = 0;
                got_o <= {gap[6:0], 1'b0, sh[8:1]};
                got_v_o <= 1'b1;
                @(posedge clk_i);
                got_v_o <= 1'b0;
            end
        end
    end
    // Async receiver: the gap field carries start and stop levels instead.
    always @(negedge txd_i) begin
        if (watch_i == 2'd2) begin
            repeat (per_i / 2) @(posedge clk_i);
            fr[0] = txd_i;
            for (int i = 1; i < (nine_i ? 11 : 10); i++) begin
                repeat (per_i) @(posedge clk_i);
                fr[i] = txd_i;
            end
            got_o <= {5'h0, fr[0], nine_i ? fr[10] : fr[9], fr[9:1]};
            got_v_o <= 1'b1;
            @(posedge clk_i);
            got_v_o <= 1'b0;
        end
    end
    // Sends start, data LSB first, ninth or stop, then stop.
    task automatic send(input logic [8:0] v, input int nb);
        logic [10:0] f;
        f = {1'b1, v, 1'b0};
        @(posedge clk_i);
        for (int i = 0; i < nb; i++) begin
            line_o <= f[i];
            repeat (per_i) @(posedge clk_i);
        end
        line_o <= 1'b1;
    endtask
    // Mode 0 slave output: a new bit after each falling shift clock.
    task automatic shift0(input logic [7:0] v);
        for (int i = 0; i < 8; i++) begin
            @(negedge txd_i);
            line_o <= v[i];
        end
        @(posedge txd_i);
        repeat (6) @(posedge clk_i);
        line_o <= 1'b1;
    endtask
endmodule

// *** test_uart_four_mode_serial_port.sv ***
// Self-checking bench for the four-mode serial port.
`timescale 1ns/100ps
module test_uart_four_mode_serial_port import ufsp_pkg::*;;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [7:0] sfr_addr_i = 8'h00;
    logic sfr_wr_i = 1'b0;
    logic sfr_rd_i = 1'b0;
    logic [7:0] sfr_wdata_i = 8'h00;
    logic [7:0] sfr_rdata_o;
    logic baud_doubler_i = 1'b0;
    logic tx_timer2_baud_select_i = 1'b0;
    logic rx_timer2_baud_select_i = 1'b0;
    logic timer1_ovf_i = 1'b0;
    logic timer2_ovf_i = 1'b0;
    logic timer2_irq_block_o;
    logic irq_enable_i = 1'b0;
    logic irq_o;
    logic rxd_o;
    logic rxd_oe_o;
    logic txd_o;
    logic p_line;
    logic p_v;
    logic [15:0] p_got;
    logic [1:0] watch = 2'd0;
    logic [7:0] per = 8'd32;
    logic nine = 1'b0;
    logic rd_d = 1'b0;
    logic [15:0] exp_q[$];
    logic [31:0] lfsr = 32'hbc27312b;
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;
    // Pull-up on the receive wire; the port can only pull it low.
    wire rxd_w = (rxd_oe_o ? rxd_o : 1'b1) & p_line;

    ufsp_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
        .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
        .baud_doubler_i(baud_doubler_i),
        .tx_timer2_baud_select_i(tx_timer2_baud_select_i),
        .rx_timer2_baud_select_i(rx_timer2_baud_select_i),
        .timer1_ovf_i(timer1_ovf_i), .timer2_ovf_i(timer2_ovf_i),
        .timer2_irq_block_o(timer2_irq_block_o),
        .irq_enable_i(irq_enable_i), .irq_o(irq_o), .rxd_i(rxd_w),
        .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o));
    ufsp_partner u_p (.clk_i(clk_i), .txd_i(txd_o), .rxd_i(rxd_w),
        .watch_i(watch), .per_i(per), .nine_i(nine), .line_o(p_line),
        .got_v_o(p_v), .got_o(p_got));

    always #5 clk_i = ~clk_i;

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic conclude();
        if (exp_q.size() != 0) begin
            miscompares++;
            $display("Error queue expected 0 seen %0d", exp_q.size());
        end
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        sfr_addr_i <= a;
        sfr_wdata_i <= d;
        sfr_wr_i <= 1'b1;
        @(posedge clk_i);
        sfr_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({8'h00, e});
        @(posedge clk_i);
        sfr_addr_i <= a;
        sfr_rd_i <= 1'b1;
        @(posedge clk_i);
        sfr_rd_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Waits for a decoded frame or for the interrupt, bounded.
    task automatic await(input bit fr);
        for (int k = 0; k < 4000; k++) begin
            @(posedge clk_i);
            if ((fr ? p_v : irq_o) === 1'b1) return;
        end
        miscompares++;
        $display("Error await %0d expected event seen timeout", fr);
    endtask

    // Timer overflows: timer 1 every 2 cycles, timer 2 every 4.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        timer1_ovf_i <= cyc[0];
        timer2_ovf_i <= (cyc[1:0] == 2'd3);
        if (cyc > 40000) begin
            miscompares++;
            conclude();
        end
    end
    // Results are paired with the oldest note as they appear.
    always @(posedge clk_i) begin
        if (rd_d) chk("read data", exp_q.pop_front(), {8'h00, sfr_rdata_o});
        if (p_v) chk("frame", exp_q.pop_front(), p_got);
        rd_d = sfr_rd_i;
    end

    initial begin
        logic [7:0] b;
        logic [7:0] c;
        logic [7:0] ct;
        logic [7:0] ct2;
        logic t8;
        logic n9;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        irq_enable_i <= 1'b1;
        rd(UFSP_CTRL_ADDR, 8'h00);
        rd(UFSP_DATA_ADDR, UFSP_REG_RESET);
        rd(8'h9a, 8'h00);
        lfsr = lfsr_next(lfsr);
        b = lfsr[7:0];
        watch <= 2'd1;
        exp_q.push_back({7'd12, 1'b0, b});
        wr(UFSP_DATA_ADDR, b);
        await(1'b1);
        chk("open drain", 16'h0, {15'h0, rxd_o});
        await(1'b0);
        rd(UFSP_CTRL_ADDR, 8'h02);
        wr(UFSP_CTRL_ADDR, 8'h00);
        watch <= 2'd0;
        lfsr = lfsr_next(lfsr);
        b = lfsr[7:0];
        fork
            u_p.shift0(b);
        join_none
        wr(UFSP_CTRL_ADDR, 8'h10);
        await(1'b0);
        rd(UFSP_DATA_ADDR, b);
        rd(UFSP_CTRL_ADDR, 8'h11);
        wr(UFSP_CTRL_ADDR, 8'h00);
        for (int m = 1; m < 4; m++) begin
            // Mode 3 sends on timer 2 and listens on halved timer 1.
            baud_doubler_i <= (m == 1);
            tx_timer2_baud_select_i <= (m == 3);
            rx_timer2_baud_select_i <= 1'b0;
            per = (m == 1) ? 8'd32 : 8'd64;
            nine = (m != 1);
            lfsr = lfsr_next(lfsr);
            {t8, n9, c, b} = lfsr[17:0];
            ct = {m[1:0], 2'b01, t8, 3'b000};
            watch <= 2'd2;
            wr(UFSP_CTRL_ADDR, ct);
            chk("timer2 mask", {15'h0, m == 3},
                {15'h0, timer2_irq_block_o});
            exp_q.push_back({7'h1, (m == 1) | t8, b});
            wr(UFSP_DATA_ADDR, b);
            await(1'b1);
            await(1'b0);
            rd(UFSP_CTRL_ADDR, ct | 8'h02);
            wr(UFSP_CTRL_ADDR, ct);
            watch <= 2'd0;
            // Received byte: the ninth bit is random, or the stop bit in mode 1.
            u_p.send({(m == 1) | n9, c}, (m == 1) ? 10 : 11);
            await(1'b0);
            rd(UFSP_DATA_ADDR, c);
            rd(UFSP_CTRL_ADDR,
                ct | {5'h0, (m == 1) | n9, 2'b01});
            u_p.send({1'b1, ~c}, (m == 1) ? 10 : 11);
            rd(UFSP_DATA_ADDR, c);
            // Mode 1 receiver off; modes 2 and 3 filter a data byte out.
            ct2 = (m == 1) ? 8'h40 : {m[1:0], 2'b11, t8, 3'b000};
            wr(UFSP_CTRL_ADDR, ct2);
            u_p.send({m == 1, ~c}, (m == 1) ? 10 : 11);
            repeat (8) @(posedge clk_i);
            rd(UFSP_CTRL_ADDR, ct2);
        end
        wr(UFSP_CTRL_ADDR, 8'h02);
        repeat (2) @(posedge clk_i);
        chk("irq", 16'h1, {15'h0, irq_o});
        // With the clock enable low the request must not follow the mask.
        irq_enable_i <= 1'b0;
        ce_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk("irq frozen", 16'h1, {15'h0, irq_o});
        ce_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk("irq masked", 16'h0, {15'h0, irq_o});
        conclude();
    end
endmodule
